// ### inc/run_ctrl_pkg.sv
package run_ctrl_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [19:0] IDX_COMMAND = 20'h00064;
    localparam logic [19:0] IDX_STATUS = 20'h0006E;
    localparam logic [19:0] IDX_MODE = 20'h0251C;
    localparam logic [19:0] IDX_MODES_AVAIL = 20'h0251D;
    localparam logic [19:0] IDX_TIMEOUT = 20'h480DA;
    localparam logic [19:0] IDX_WAIT_RESULT = 20'h480E0;
    localparam logic [19:0] IDX_ERRORS = 20'h480E1;

    ////////////////////////////////////////////////////////////////////////////////
    // Command register bit positions
    localparam int CMD_RESET = 0;
    localparam int CMD_SETUP = 1;
    localparam int CMD_START = 2;
    localparam int CMD_TRIG_ON = 3;
    localparam int CMD_TRIG_FORCE = 4;
    localparam int CMD_TRIG_OFF = 5;
    localparam int CMD_STOP = 6;
    localparam int CMD_FLUSH = 7;
    localparam int CMD_WAIT_PRE = 12;
    localparam int CMD_WAIT_TRIG = 13;
    localparam int CMD_WAIT_DONE = 14;

    // Error register bit positions (write one to clear)
    localparam int ERR_SEQ = 0;
    localparam int ERR_MODE = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode bitmap
    localparam logic [7:0] MODE_MEM_SINGLE = 8'h01;
    localparam logic [7:0] MODE_MEM_MULTI = 8'h02;
    localparam logic [7:0] MODE_MEM_GATED = 8'h04;
    localparam logic [7:0] MODE_MEM_DUAL = 8'h08;
    localparam logic [7:0] MODE_STREAM_SINGLE = 8'h10;
    localparam logic [7:0] MODE_STREAM_MULTI = 8'h20;
    localparam logic [7:0] MODE_STREAM_GATED = 8'h40;
    localparam logic [7:0] MODE_STREAM_DUAL = 8'h80;
    localparam logic [7:0] MODE_STREAM_MASK = 8'hF0;
    localparam logic [7:0] MODE_MULTI_MASK = 8'hEE;
    localparam logic [7:0] MODE_ALL = 8'hFF;
    localparam logic [7:0] MODE_DEFAULT = MODE_MEM_SINGLE;
    localparam logic [31:0] TIMEOUT_DEFAULT = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_HZ = 100_000_000;
    localparam int WAIT_TICK_MS = 1;
    localparam int CYCLES_PER_TICK = CLK_HZ / 1000 * WAIT_TICK_MS;

    ////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {RUN_IDLE, RUN_FILL, RUN_ARMED, RUN_POST} run_state_t;
    typedef enum logic [2:0] {WAIT_NONE, WAIT_BUSY, WAIT_OK, WAIT_TIMEOUT, WAIT_ABORT}
        wait_result_t;

    typedef struct packed {
        logic run_done;
        logic triggered;
        logic pretrig_full;
    } card_status_t;

    typedef struct packed {
        logic mode_err;
        logic seq_err;
    } err_flags_t;

endpackage

// ### rtl/sync2.sv
module sync2 (
    input wire logic clk,   // Card clock
    input wire logic rst_n, // Async reset, low
    input wire logic d,     // Foreign level
    output logic q          // Synchronised level
);

    logic meta;

    ////////////////////////////////////////////////////////////////////////////////
    // Two stages; only the second stage is read outside
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end

endmodule // sync2

// ### rtl/wait_timer.sv
module wait_timer #(
    parameter int unsigned TICK_CYCLES = 100000
) (
    input wire logic clk,             // Card clock
    input wire logic rst_n,           // Async reset, low
    input wire logic arm,             // Start a new wait
    input wire logic halt,            // Wait finished otherwise
    input wire logic [31:0] limit_ms, // Timeout, zero disables
    output logic expired              // One-cycle expiry pulse
);

    logic running;
    logic [31:0] pre;
    logic [31:0] ms;
    logic [31:0] lim;

    wire tick = running && (pre == 32'(TICK_CYCLES - 1));
    wire last = (ms + 32'h0000_0001) == lim;

    ////////////////////////////////////////////////////////////////////////////////
    // Limit latched at arm, so a later register write hits the next wait only
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            running <= 1'b0;
            pre <= 32'h0;
            ms <= 32'h0;
            lim <= 32'h0;
            expired <= 1'b0;
        end
        else if (arm)
        begin
            running <= (limit_ms != 32'h0);
            pre <= 32'h0;
            ms <= 32'h0;
            lim <= limit_ms;
            expired <= 1'b0;
        end
        else
        begin
            expired <= tick && last && !halt;
            if (halt || (tick && last))
                running <= 1'b0;
            if (tick)
            begin
                pre <= 32'h0;
                ms <= ms + 32'h0000_0001;
            end
            else if (running)
                pre <= pre + 32'h0000_0001;
        end
    end

endmodule // wait_timer

// ### rtl/run_control.sv
// What this block does
// - Mode bits: memory 1h-8h, stream 10h-80h
// - Read-only bitmap of supported modes
// - Mode read shows active, write sets next
// - Stream modes circular, memory modes stop full
// - Command bits combine; illegal combos flag error
// - 1h resets card, run back to idle
// - 2h applies pending setup without starting
// - 4h applies changed setup then starts
// - 8h enables trigger, with or after start
// - 10h forces a trigger immediately
// - 20h disables trigger; runs start disabled
// - 40h stops run; ignored when idle
// - 80h flushes buffers after mid-run stop
// - 1000h waits pretrigger full; then triggers count
// - 2000h waits first trigger; first only
// - 4000h waits run finished
// - Wait ends ok, timeout or abort
// - Millisecond timeout register, zero disables
// - Timeout leaves the run untouched
// - Status bits: pretrigger, triggered, done
// - Sequence: pretrigger, trigger, posttrigger, done
module run_control #(
    parameter logic [7:0] SUPPORTED = run_ctrl_pkg::MODE_ALL,
    parameter int unsigned MS_CYCLES = run_ctrl_pkg::CYCLES_PER_TICK
) (
    input wire logic MCLK,                   // 100 MHz card clock
    input wire logic RESET_N,                // Async reset, low
    input wire logic [19:0] AVS_ADDRESS,     // Word index
    input wire logic AVS_READ,               // Read request
    input wire logic AVS_WRITE,              // Write request
    input wire logic [31:0] AVS_WRITEDATA,   // Write data
    input wire logic [3:0] AVS_BYTEENABLE,   // Byte lanes
    output logic [31:0] AVS_READDATA,        // Read data
    output logic AVS_WAITREQUEST,            // Stall
    input wire logic TRIGGER_PIN,            // External trigger pin
    input wire logic PRETRIG_FILLED,         // Datapath: pretrigger full pulse
    input wire logic POST_DONE,              // Datapath: posttrigger done pulse
    input wire logic MEMORY_FULL,            // Datapath: memory full level
    output logic RUN_ACTIVE,                 // Run in progress
    output logic TRIGGER_ENABLE,             // Trigger detection on
    output logic ACQ_TRIGGER,                // Trigger pulse to datapath
    output logic CIRCULAR_BUFFER,            // Whole memory as ring
    output logic SETUP_LOAD,                 // Setup apply pulse
    output logic [7:0] ACTIVE_MODE,          // Mode in use
    output logic FLUSH_BUFFERS,              // Flush pulse
    output logic CARD_RESET,                 // Reset pulse to datapath
    output logic IRQ_PRETRIG,                // Pretrigger full pulse
    output logic IRQ_TRIGGER,                // First trigger pulse
    output logic IRQ_DONE                    // Run done pulse
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    run_ctrl_pkg::run_state_t state;
    run_ctrl_pkg::run_state_t next_state;
    run_ctrl_pkg::wait_result_t wait_res;
    run_ctrl_pkg::card_status_t stat;
    run_ctrl_pkg::err_flags_t errs;
    logic ack;
    logic [7:0] sel_mode;
    logic cfg_dirty;
    logic [31:0] timeout_ms;
    logic [2:0] wait_mask;
    logic stopped_mid;
    logic trig_q;
    logic trig_prev;
    logic expired;
    logic [31:0] rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait state; read data captured at the edge that raises ack, write taken one edge later
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack;

    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
            ack <= 1'b0;
        else
            ack <= (AVS_READ || AVS_WRITE) && !ack;
    end

    wire wr_go = AVS_WRITE && ack;
    wire [31:0] be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                           {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
    wire [31:0] wd = AVS_WRITEDATA & be_mask;
    wire wr_cmd = wr_go && (AVS_ADDRESS == run_ctrl_pkg::IDX_COMMAND);
    wire wr_mode = wr_go && (AVS_ADDRESS == run_ctrl_pkg::IDX_MODE);
    wire wr_tmo = wr_go && (AVS_ADDRESS == run_ctrl_pkg::IDX_TIMEOUT);
    wire wr_err = wr_go && (AVS_ADDRESS == run_ctrl_pkg::IDX_ERRORS);

    ////////////////////////////////////////////////////////////////////////////////
    // Read decode; unmapped and write-only addresses read zero
    always_comb
    begin
        if (AVS_ADDRESS == run_ctrl_pkg::IDX_STATUS)
            rdata = {29'h0, stat};
        else if (AVS_ADDRESS == run_ctrl_pkg::IDX_MODE)
            rdata = {24'h0, ACTIVE_MODE};
        else if (AVS_ADDRESS == run_ctrl_pkg::IDX_MODES_AVAIL)
            rdata = {24'h0, SUPPORTED};
        else if (AVS_ADDRESS == run_ctrl_pkg::IDX_TIMEOUT)
            rdata = timeout_ms;
        else if (AVS_ADDRESS == run_ctrl_pkg::IDX_WAIT_RESULT)
            rdata = {25'h0, wait_mask, 1'b0, wait_res};
        else if (AVS_ADDRESS == run_ctrl_pkg::IDX_ERRORS)
            rdata = {30'h0, errs};
        else
            rdata = 32'h0;
    end

    // Read data captured on the edge that ends the wait state
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
            AVS_READDATA <= 32'h0;
        else if (AVS_READ && !ack)
            AVS_READDATA <= rdata;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command bits
    wire c_reset = wd[run_ctrl_pkg::CMD_RESET];
    wire c_setup = wd[run_ctrl_pkg::CMD_SETUP];
    wire c_start = wd[run_ctrl_pkg::CMD_START];
    wire c_ton = wd[run_ctrl_pkg::CMD_TRIG_ON];
    wire c_force = wd[run_ctrl_pkg::CMD_TRIG_FORCE];
    wire c_toff = wd[run_ctrl_pkg::CMD_TRIG_OFF];
    wire c_stop = wd[run_ctrl_pkg::CMD_STOP];
    wire c_flush = wd[run_ctrl_pkg::CMD_FLUSH];
    wire [2:0] c_wait = {wd[run_ctrl_pkg::CMD_WAIT_DONE], wd[run_ctrl_pkg::CMD_WAIT_TRIG],
                         wd[run_ctrl_pkg::CMD_WAIT_PRE]};
    wire running = (state != run_ctrl_pkg::RUN_IDLE);

    // Combinations refused as a whole; the write then only sets the sequence error flag
    wire trig_cmd = c_ton || c_force || c_toff;
    wire others = c_setup || c_start || trig_cmd || c_stop || c_flush || (|c_wait);
    wire seq_bad = (c_reset && others)
        || (c_start && (running || c_stop))
        || (c_setup && running)
        || (trig_cmd && !running && !c_start)
        || (c_ton && c_toff)
        || (c_flush && (running || c_start))
        || ((|c_wait) && (wait_res == run_ctrl_pkg::WAIT_BUSY));
    wire cmd_ok = wr_cmd && !seq_bad;
    wire do_reset = cmd_ok && c_reset;
    wire do_start = cmd_ok && c_start;
    wire do_stop = cmd_ok && c_stop && running;
    wire do_force = cmd_ok && c_force;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode write check: one bit, and supported by the options fitted
    wire mode_onehot = (wd[7:0] != 8'h00) && ((wd[7:0] & (wd[7:0] - 8'h01)) == 8'h00);
    wire mode_legal = mode_onehot && (wd[31:8] == 24'h0)
        && ((wd[7:0] & SUPPORTED) == wd[7:0]);
    wire apply_cfg = cmd_ok && (c_setup || (c_start && cfg_dirty));

    // Pending setup kept apart from the active one so a write mid-run waits
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            sel_mode <= run_ctrl_pkg::MODE_DEFAULT;
            cfg_dirty <= 1'b0;
            ACTIVE_MODE <= run_ctrl_pkg::MODE_DEFAULT;
        end
        else if (do_reset)
        begin
            sel_mode <= run_ctrl_pkg::MODE_DEFAULT;
            cfg_dirty <= 1'b0;
            ACTIVE_MODE <= run_ctrl_pkg::MODE_DEFAULT;
        end
        else if (wr_mode && mode_legal)
        begin
            sel_mode <= wd[7:0];
            cfg_dirty <= 1'b1;
        end
        else if (apply_cfg)
        begin
            ACTIVE_MODE <= sel_mode;
            cfg_dirty <= 1'b0;
        end
    end

    // Stream modes recirculate through all sample memory
    assign CIRCULAR_BUFFER = |(ACTIVE_MODE & run_ctrl_pkg::MODE_STREAM_MASK);
    wire multi_trig = |(ACTIVE_MODE & run_ctrl_pkg::MODE_MULTI_MASK);

    ////////////////////////////////////////////////////////////////////////////////
    // Wait timeout register
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
            timeout_ms <= run_ctrl_pkg::TIMEOUT_DEFAULT;
        else if (do_reset)
            timeout_ms <= run_ctrl_pkg::TIMEOUT_DEFAULT;
        else if (wr_tmo)
            timeout_ms <= (AVS_WRITEDATA & be_mask) | (timeout_ms & ~be_mask);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky errors; a new error beats a clear in the same cycle
    wire set_mode = wr_mode && !mode_legal;
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
            errs <= '0;
        else
        begin
            errs.seq_err <= (errs.seq_err && !(wr_err && wd[run_ctrl_pkg::ERR_SEQ]))
                || (wr_cmd && seq_bad);
            errs.mode_err <= (errs.mode_err && !(wr_err && wd[run_ctrl_pkg::ERR_MODE]))
                || set_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Trigger pin: synchronised, then rising edge
    sync2 u_trig_sync (
        .clk(MCLK),
        .rst_n(RESET_N),
        .d(TRIGGER_PIN),
        .q(trig_q)
    );

    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
            trig_prev <= 1'b0;
        else
            trig_prev <= trig_q;
    end

    wire trig_edge = trig_q && !trig_prev;
    // Real triggers only count once pretrigger is full and detection is on
    wire real_trig = (state == run_ctrl_pkg::RUN_ARMED) && TRIGGER_ENABLE && trig_edge;
    wire force_hit = do_force && (state != run_ctrl_pkg::RUN_POST);
    wire first_trig = real_trig || force_hit;
    wire later_trig = (state == run_ctrl_pkg::RUN_POST) && multi_trig
        && ((TRIGGER_ENABLE && trig_edge) || do_force);
    // Memory modes end when memory runs out; stream modes never do
    wire mem_stop = MEMORY_FULL && !CIRCULAR_BUFFER;
    wire run_end = (state == run_ctrl_pkg::RUN_POST) && (POST_DONE || mem_stop);
    wire pre_hit = (state == run_ctrl_pkg::RUN_FILL) && PRETRIG_FILLED;

    ////////////////////////////////////////////////////////////////////////////////
    // Run sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            run_ctrl_pkg::RUN_IDLE:
                if (do_start)
                    next_state = do_force ? run_ctrl_pkg::RUN_POST
                        : run_ctrl_pkg::RUN_FILL;
            run_ctrl_pkg::RUN_FILL:
                if (force_hit)
                    next_state = run_ctrl_pkg::RUN_POST;
                else if (PRETRIG_FILLED)
                    next_state = run_ctrl_pkg::RUN_ARMED;
            run_ctrl_pkg::RUN_ARMED:
                if (first_trig)
                    next_state = run_ctrl_pkg::RUN_POST;
            run_ctrl_pkg::RUN_POST:
                if (POST_DONE || mem_stop)
                    next_state = run_ctrl_pkg::RUN_IDLE;
            default:
                next_state = run_ctrl_pkg::RUN_IDLE;
        endcase
        if (do_reset || do_stop)
            next_state = run_ctrl_pkg::RUN_IDLE;
    end

    // Timeout expiry never enters here, so the run carries on
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
            state <= run_ctrl_pkg::RUN_IDLE;
        else
            state <= next_state;
    end

    assign RUN_ACTIVE = running;

    ////////////////////////////////////////////////////////////////////////////////
    // Trigger enable: cleared at every start unless enabled in the same write
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
            TRIGGER_ENABLE <= 1'b0;
        else if (do_reset || do_stop)
            TRIGGER_ENABLE <= 1'b0;
        else if (cmd_ok && c_ton)
            TRIGGER_ENABLE <= 1'b1;
        else if (cmd_ok && (c_toff || c_start))
            TRIGGER_ENABLE <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status flags, cleared at start and reset; set only while running
    wire set_trig = first_trig && !stat.triggered;
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
            stat <= '0;
        else if (do_reset || do_start)
            stat <= '0;
        else
        begin
            if (pre_hit)
                stat.pretrig_full <= 1'b1;
            if (set_trig)
                stat.triggered <= 1'b1;
            if (run_end)
                stat.run_done <= 1'b1;
        end
    end

    // One pulse per condition per run, taken from the flag's first rise
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            IRQ_PRETRIG <= 1'b0;
            IRQ_TRIGGER <= 1'b0;
            IRQ_DONE <= 1'b0;
        end
        else
        begin
            IRQ_PRETRIG <= pre_hit && !stat.pretrig_full;
            IRQ_TRIGGER <= set_trig;
            IRQ_DONE <= run_end && !stat.run_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pulses to the datapath
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            ACQ_TRIGGER <= 1'b0;
            SETUP_LOAD <= 1'b0;
            FLUSH_BUFFERS <= 1'b0;
            CARD_RESET <= 1'b0;
        end
        else
        begin
            ACQ_TRIGGER <= first_trig || later_trig;
            SETUP_LOAD <= apply_cfg;
            FLUSH_BUFFERS <= cmd_ok && c_flush && stopped_mid;
            CARD_RESET <= do_reset;
        end
    end

    // A flush is only meaningful after a stop cut a run short
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
            stopped_mid <= 1'b0;
        else if (do_stop)
            stopped_mid <= 1'b1;
        else if (do_reset || do_start || (cmd_ok && c_flush))
            stopped_mid <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wait engine
    wire wait_arm = cmd_ok && (|c_wait);
    wire wait_busy = (wait_res == run_ctrl_pkg::WAIT_BUSY);
    wire wait_met = wait_busy && (|(wait_mask & stat));
    wire wait_abort = wait_busy && (do_stop || do_reset);
    wire wait_tmo = wait_busy && expired;

    wait_timer #(
        .TICK_CYCLES(MS_CYCLES)
    ) u_wait_timer (
        .clk(MCLK),
        .rst_n(RESET_N),
        .arm(wait_arm),
        .halt(wait_met || wait_abort),
        .limit_ms(timeout_ms),
        .expired(expired)
    );

    // Abort outranks success and timeout in the same cycle
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            wait_res <= run_ctrl_pkg::WAIT_NONE;
            wait_mask <= 3'h0;
        end
        else if (wait_arm)
        begin
            wait_res <= run_ctrl_pkg::WAIT_BUSY;
            wait_mask <= c_wait;
        end
        else if (wait_abort)
        begin
            wait_res <= run_ctrl_pkg::WAIT_ABORT;
            wait_mask <= 3'h0;
        end
        else if (wait_met)
        begin
            wait_res <= run_ctrl_pkg::WAIT_OK;
            wait_mask <= 3'h0;
        end
        else if (wait_tmo)
        begin
            wait_res <= run_ctrl_pkg::WAIT_TIMEOUT;
            wait_mask <= 3'h0;
        end
    end

endmodule // run_control

// ### tb/run_control_sva.sv
// Port-level checks of the run-control core
module run_control_sva (
    input wire logic MCLK,              // Card clock
    input wire logic RESET_N,           // Async reset, low
    input wire logic AVS_READ,          // Read request
    input wire logic AVS_WRITE,         // Write request
    input wire logic AVS_WAITREQUEST,   // Stall
    input wire logic RUN_ACTIVE,        // Run in progress
    input wire logic TRIGGER_ENABLE,    // Trigger on
    input wire logic ACQ_TRIGGER,       // Trigger pulse
    input wire logic CIRCULAR_BUFFER,   // Ring memory
    input wire logic [7:0] ACTIVE_MODE, // Mode in use
    input wire logic FLUSH_BUFFERS,     // Flush pulse
    input wire logic CARD_RESET,        // Reset pulse
    input wire logic IRQ_DONE           // Done pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    // One domain, so clock and reset are given once
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESET_N);
    ////////////////////////////////////////////////////////////
    // Bus answers after exactly one wait state
    a_write_one_wait: assert property ($rose(AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("write wait state count wrong");
    a_read_one_wait: assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("read wait state count wrong");
    a_ring_decode: assert property (CIRCULAR_BUFFER == (|(ACTIVE_MODE & 8'hF0)))
        else $error("ring flag does not match mode");
    a_mode_one_hot: assert property ($onehot(ACTIVE_MODE))
        else $error("active mode not one-hot");
    // Pulses last one cycle; no trigger leaks out of an idle card
    a_trig_pulse: assert property (ACQ_TRIGGER |=> !ACQ_TRIGGER)
        else $error("trigger pulse too long");
    a_idle_no_trig: assert property (!RUN_ACTIVE && !$past(RUN_ACTIVE) |-> !ACQ_TRIGGER)
        else $error("trigger while idle");
    a_done_once: assert property (IRQ_DONE |=> !IRQ_DONE)
        else $error("done request too long");
    a_reset_idle: assert property (CARD_RESET |-> !RUN_ACTIVE && !TRIGGER_ENABLE)
        else $error("soft reset left run state");
    a_flush_idle: assert property (FLUSH_BUFFERS |-> !RUN_ACTIVE)
        else $error("flush while running");
endmodule // run_control_sva

bind run_control run_control_sva u_sva (.MCLK(MCLK), .RESET_N(RESET_N), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .RUN_ACTIVE(RUN_ACTIVE),
    .TRIGGER_ENABLE(TRIGGER_ENABLE), .ACQ_TRIGGER(ACQ_TRIGGER),
    .CIRCULAR_BUFFER(CIRCULAR_BUFFER), .ACTIVE_MODE(ACTIVE_MODE),
    .FLUSH_BUFFERS(FLUSH_BUFFERS), .CARD_RESET(CARD_RESET), .IRQ_DONE(IRQ_DONE));

// ### tb/acq_card_run_control_tb.sv
module acq_card_run_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, rst_n = 1'b0, rd_en = 1'b0, wr_en = 1'b0, pin = 1'b0;
    logic [1:0] dp = 2'h0;
    logic [19:0] addr = 20'h0;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic wait_req, run, trig_en, circ;
    logic [6:0] hit = 7'h00;
    wire [6:0] pl;
    int mismatches = 0, total_checks = 0;
    // Short millisecond so timeouts fit the run
    run_control #(.MS_CYCLES(10)) u_dut (.MCLK(mclk), .RESET_N(rst_n), .AVS_ADDRESS(addr),
        .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .TRIGGER_PIN(pin),
        .PRETRIG_FILLED(dp[0]), .POST_DONE(dp[1]), .MEMORY_FULL(1'b0), .RUN_ACTIVE(run),
        .TRIGGER_ENABLE(trig_en), .ACQ_TRIGGER(pl[0]), .CIRCULAR_BUFFER(circ),
        .SETUP_LOAD(pl[1]), .ACTIVE_MODE(), .FLUSH_BUFFERS(pl[2]), .CARD_RESET(pl[3]),
        .IRQ_PRETRIG(pl[4]), .IRQ_TRIGGER(pl[5]), .IRQ_DONE(pl[6]));
    initial
        forever #5 mclk = ~mclk;
    // Sticky record of each one-cycle pulse, since register reads miss them
    always @(posedge mclk)
        hit <= rst_n ? (hit | pl) : 7'h00;
    ////////////////////////////////////////////////////////////
    // Verdict and comparison helpers
    task automatic end_sim;
        if (mismatches == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One bus cycle; held until waitrequest is seen low, bounded
    task automatic bus(logic wr, logic [19:0] a, logic [31:0] d);
        int n = 0;
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_en <= wr;
        rd_en <= !wr;
        @(posedge mclk);
        while (wait_req !== 1'b0)
        begin
            n++;
            if (n > 20)
            begin
                mismatches++;
                end_sim();
            end
            @(posedge mclk);
        end
        rv = rdata;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask
    task automatic rd(string w, logic [19:0] a, logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(w, rv, e);
    endtask
    task automatic wr(logic [19:0] a, logic [31:0] d);
        bus(1'b1, a, d);
        @(negedge mclk);
    endtask
    // Datapath pulse, then a rising pin edge held past the synchroniser
    task automatic pulse(logic [1:0] v);
        @(posedge mclk);
        dp <= v;
        @(posedge mclk);
        dp <= 2'h0;
    endtask
    task automatic pin_edge;
        @(posedge mclk);
        pin <= 1'b1;
        repeat (6) @(posedge mclk);
        pin <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////
    // Main sequence: registers, modes, errors, a full run, timeout and abort
    initial
    begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        rd("mode", run_ctrl_pkg::IDX_MODE, 32'h1);
        rd("avail", run_ctrl_pkg::IDX_MODES_AVAIL, 32'hFF);
        rd("timeout", run_ctrl_pkg::IDX_TIMEOUT, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            wr(run_ctrl_pkg::IDX_MODE, 32'h1 << i);
            wr(run_ctrl_pkg::IDX_COMMAND, 32'h2);
            rd("mode", run_ctrl_pkg::IDX_MODE, 32'h1 << i);
            chk("ring", 32'(circ), 32'(i > 3));
        end
        wr(run_ctrl_pkg::IDX_MODE, 32'h3);
        rd("mode", run_ctrl_pkg::IDX_MODE, 32'h80);
        rd("err", run_ctrl_pkg::IDX_ERRORS, 32'h2);
        wr(run_ctrl_pkg::IDX_ERRORS, 32'h3);
        wr(run_ctrl_pkg::IDX_COMMAND, 32'h5);
        rd("err", run_ctrl_pkg::IDX_ERRORS, 32'h1);
        wr(run_ctrl_pkg::IDX_ERRORS, 32'h3);
        wr(run_ctrl_pkg::IDX_COMMAND, 32'h40);
        rd("err", run_ctrl_pkg::IDX_ERRORS, 32'h0);
        wr(run_ctrl_pkg::IDX_MODE, 32'h1);
        wr(run_ctrl_pkg::IDX_COMMAND, 32'h4);
        chk("run", 32'(run), 32'h1);
        chk("ring", 32'(circ), 32'h0);
        chk("trig_en", 32'(trig_en), 32'h0);
        wr(run_ctrl_pkg::IDX_COMMAND, 32'h1000);
        pulse(2'h1);
        rd("status", run_ctrl_pkg::IDX_STATUS, 32'h1);
        rd("wait", run_ctrl_pkg::IDX_WAIT_RESULT, 32'h2);
        pin_edge();
        rd("status", run_ctrl_pkg::IDX_STATUS, 32'h1);
        wr(run_ctrl_pkg::IDX_COMMAND, 32'h8);
        chk("trig_en", 32'(trig_en), 32'h1);
        pin_edge();
        rd("status", run_ctrl_pkg::IDX_STATUS, 32'h3);
        pulse(2'h2);
        rd("status", run_ctrl_pkg::IDX_STATUS, 32'h7);
        wr(run_ctrl_pkg::IDX_TIMEOUT, 32'h2);
        wr(run_ctrl_pkg::IDX_COMMAND, 32'hC);
        chk("trig_en", 32'(trig_en), 32'h1);
        wr(run_ctrl_pkg::IDX_COMMAND, 32'h2000);
        repeat (30) @(negedge mclk);
        rd("wait", run_ctrl_pkg::IDX_WAIT_RESULT, 32'h3);
        chk("run", 32'(run), 32'h1);
        wr(run_ctrl_pkg::IDX_COMMAND, 32'h10);
        rd("status", run_ctrl_pkg::IDX_STATUS, 32'h2);
        wr(run_ctrl_pkg::IDX_COMMAND, 32'h4000);
        wr(run_ctrl_pkg::IDX_COMMAND, 32'h40);
        rd("wait", run_ctrl_pkg::IDX_WAIT_RESULT, 32'h4);
        chk("run", 32'(run), 32'h0);
        wr(run_ctrl_pkg::IDX_COMMAND, 32'h80);
        wr(run_ctrl_pkg::IDX_COMMAND, 32'h1);
        rd("timeout", run_ctrl_pkg::IDX_TIMEOUT, 32'h0);
        chk("pulses", 32'(hit), 32'h7F);
        end_sim();
    end
endmodule // acq_card_run_control_tb
